// ==== logic/mpw_wake_detector.v ====
// Wake-on-LAN magic packet detector with wake pin, interrupt merge and isolate
`timescale 1ns/100ps
`include "mpw_defines.vh"

module mpw_wake_detector (
    input wire clk_sys,
    input wire arst_n,
    input wire [15:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_wdata,
    output reg [15:0] reg_rdata,
    input wire rx_frame_start,
    input wire rx_byte_valid,
    input wire [7:0] rx_byte,
    input wire rx_frame_end,
    input wire rx_frame_good,
    input wire wake_strap_pad,
    input wire led_activity,
    output reg status_light_zero_o,
    output reg status_light_zero_oe,
    input wire other_int_n,
    output wire general_interrupt_pin_o,
    output reg general_interrupt_pin_oe,
    input wire [3:0] core_rxd,
    input wire core_rx_dv,
    input wire core_rx_er,
    input wire core_crs,
    input wire core_col,
    output reg [3:0] mac_rxd_o,
    output reg mac_rx_dv_o,
    output reg mac_rx_er_o,
    output reg mac_crs_o,
    output reg mac_col_o,
    output reg mac_out_oe,
    input wire [3:0] mac_txd_i,
    input wire mac_tx_en_i,
    input wire mac_tx_er_i,
    output reg [3:0] core_txd,
    output reg core_tx_en,
    output reg core_tx_er
);

    reg [15:0] basic_control_r;
    reg [15:0] interrupt_enable_r;
    reg [15:0] wake_control_r;
    reg [15:0] wake_output_config_r;
    reg [15:0] station_w0_r;
    reg [15:0] station_w1_r;
    reg [15:0] station_w2_r;
    reg wake_seen_r;
    reg int_wake_r;
    reg strap_done_r;
    reg strap_wake_r;
    reg pulse_act_r;
    reg [15:0] pulse_cnt_r;
    reg [15:0] pulse_len;
    reg [15:0] rdata_nxt;
    wire found;

    wire wr_hit = reg_wr;
    wire detect_en = wake_control_r[`MPW_BIT_WAKE_EN];
    wire pulse_mode = wake_output_config_r[`MPW_BIT_PULSE_MODE];
    wire [1:0] pw_sel = wake_output_config_r[`MPW_BIT_PW_HI:`MPW_BIT_PW_LO];
    wire isolate = basic_control_r[`MPW_BIT_ISOLATE];
    wire rd_status = reg_rd && (reg_addr == `MPW_OFS_INT_STATUS);
    wire wr_wake_ctrl = wr_hit && (reg_addr == `MPW_OFS_WAKE_CTRL);
    wire seen_clr = wr_wake_ctrl && reg_wdata[`MPW_BIT_WAKE_SEEN];

    // Only magic packets are searched for; no other wake pattern exists
    mpw_pattern_match u_match (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .enable(detect_en),
        .frame_start(rx_frame_start),
        .byte_valid(rx_byte_valid),
        .byte_data(rx_byte),
        .station_addr({station_w0_r, station_w1_r, station_w2_r}),
        .found(found)
    );

    // Frames with bad check sequence or errors never wake
    wire wake_event = detect_en && rx_frame_end && rx_frame_good && found;

    // Register writes
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            basic_control_r <= `MPW_RST_BASIC_CTRL;
            interrupt_enable_r <= `MPW_RST_INT_ENABLE;
            wake_control_r <= `MPW_RST_WAKE_CTRL;
            wake_output_config_r <= `MPW_RST_WAKE_OUT_CFG;
            station_w0_r <= `MPW_RST_STATION;
            station_w1_r <= `MPW_RST_STATION;
            station_w2_r <= `MPW_RST_STATION;
        end else if (wr_hit) begin
            case (reg_addr)
                `MPW_OFS_BASIC_CTRL: begin
                    basic_control_r <= reg_wdata;
                end
                `MPW_OFS_INT_ENABLE: begin
                    interrupt_enable_r <= reg_wdata;
                end
                `MPW_OFS_WAKE_CTRL: begin
                    // Seen bit lives in its own flop
                    wake_control_r <= reg_wdata & ~(16'h0001 << `MPW_BIT_WAKE_SEEN);
                end
                `MPW_OFS_WAKE_OUT_CFG: begin
                    wake_output_config_r <= reg_wdata;
                end
                `MPW_OFS_STATION_W0: begin
                    station_w0_r <= reg_wdata;
                end
                `MPW_OFS_STATION_W1: begin
                    station_w1_r <= reg_wdata;
                end
                `MPW_OFS_STATION_W2: begin
                    station_w2_r <= reg_wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // Sticky wake status; a new event beats a clear in the same cycle
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wake_seen_r <= 1'b0;
        end else if (wake_event) begin
            wake_seen_r <= 1'b1;
        end else if (seen_clr || !detect_en) begin
            wake_seen_r <= 1'b0;
        end
    end

    // Interrupt cause bit, cleared by reading the status register
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            int_wake_r <= 1'b0;
        end else if (wake_event) begin
            int_wake_r <= 1'b1;
        end else if (rd_status) begin
            int_wake_r <= 1'b0;
        end
    end

    always @* begin
        case (pw_sel)
            2'h0: pulse_len = `MPW_PW_CYC0;
            2'h1: pulse_len = `MPW_PW_CYC1;
            2'h2: pulse_len = `MPW_PW_CYC2;
            2'h3: pulse_len = `MPW_PW_CYC3;
            default: pulse_len = `MPW_PW_CYC0;
        endcase
    end

    // Pulse generator; a new event during a pulse restarts the width
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pulse_act_r <= 1'b0;
            pulse_cnt_r <= 16'h0000;
        end else if (wake_event && pulse_mode) begin
            pulse_act_r <= 1'b1;
            pulse_cnt_r <= pulse_len - 16'h0001;
        end else if (!pulse_mode || !detect_en) begin
            pulse_act_r <= 1'b0;
            pulse_cnt_r <= 16'h0000;
        end else if (pulse_act_r) begin
            if (pulse_cnt_r == 16'h0000)
                pulse_act_r <= 1'b0;
            else
                pulse_cnt_r <= pulse_cnt_r - 16'h0001;
        end
    end

    // Level mode follows the sticky status, pulse mode the timer
    wire wake_active = pulse_mode ? pulse_act_r : (wake_seen_r && detect_en);
    wire wake_n = ~wake_active;

    // Strap is taken once, the first edge after reset release
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            strap_done_r <= 1'b0;
            strap_wake_r <= 1'b0;
        end else if (!strap_done_r) begin
            strap_done_r <= 1'b1;
            strap_wake_r <= wake_strap_pad;
        end
    end

    // Pin floats until the strap is latched so the pull-up is not fought
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            status_light_zero_o <= 1'b1;
            status_light_zero_oe <= 1'b0;
        end else begin
            status_light_zero_oe <= strap_done_r;
            status_light_zero_o <= strap_wake_r ? wake_n : led_activity;
        end
    end

    // Open drain: the pin is only ever pulled low, so the level is constant
    // In level mode the wake term stays until status clear, not on read
    wire wake_int_term = interrupt_enable_r[`MPW_BIT_INT_WAKE] &&
                         (pulse_mode ? int_wake_r : wake_active);
    assign general_interrupt_pin_o = 1'b0;

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            general_interrupt_pin_oe <= 1'b0;
        end else begin
            general_interrupt_pin_oe <= wake_int_term || !other_int_n;
        end
    end

    // MAC-side pass-through; isolate floats outputs and masks inputs
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mac_rxd_o <= 4'h0;
            mac_rx_dv_o <= 1'b0;
            mac_rx_er_o <= 1'b0;
            mac_crs_o <= 1'b0;
            mac_col_o <= 1'b0;
            mac_out_oe <= 1'b0;
            core_txd <= 4'h0;
            core_tx_en <= 1'b0;
            core_tx_er <= 1'b0;
        end else begin
            mac_rxd_o <= core_rxd;
            mac_rx_dv_o <= core_rx_dv;
            mac_rx_er_o <= core_rx_er;
            mac_crs_o <= core_crs;
            mac_col_o <= core_col;
            mac_out_oe <= !isolate;
            if (isolate) begin
                core_txd <= 4'h0;
                core_tx_en <= 1'b0;
                core_tx_er <= 1'b0;
            end else begin
                core_txd <= mac_txd_i;
                core_tx_en <= mac_tx_en_i;
                core_tx_er <= mac_tx_er_i;
            end
        end
    end

    // Read mux; unmapped addresses return zero
    always @* begin
        case (reg_addr)
            `MPW_OFS_BASIC_CTRL: rdata_nxt = basic_control_r;
            `MPW_OFS_INT_ENABLE: rdata_nxt = interrupt_enable_r;
            `MPW_OFS_INT_STATUS: rdata_nxt = {9'h000, int_wake_r, 6'h00};
            `MPW_OFS_WAKE_CTRL: rdata_nxt = wake_control_r | ({15'h0000, wake_seen_r} << `MPW_BIT_WAKE_SEEN);
            `MPW_OFS_WAKE_OUT_CFG: rdata_nxt = wake_output_config_r;
            `MPW_OFS_STATION_W0: rdata_nxt = station_w0_r;
            `MPW_OFS_STATION_W1: rdata_nxt = station_w1_r;
            `MPW_OFS_STATION_W2: rdata_nxt = station_w2_r;
            default: rdata_nxt = 16'h0000;
        endcase
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end
    end

endmodule

// ==== logic/mpw_defines.vh ====
// Register map, field positions, reset values and timing counts of the wake detector
`ifndef MPW_DEFINES_VH
`define MPW_DEFINES_VH

`define MPW_OFS_BASIC_CTRL 16'h0000
`define MPW_OFS_INT_ENABLE 16'h0012
`define MPW_OFS_INT_STATUS 16'h0013
`define MPW_OFS_WAKE_CTRL 16'h4000
`define MPW_OFS_WAKE_OUT_CFG 16'h4003
`define MPW_OFS_STATION_W0 16'h4004
`define MPW_OFS_STATION_W1 16'h4005
`define MPW_OFS_STATION_W2 16'h4006

`define MPW_BIT_ISOLATE 10
`define MPW_BIT_INT_WAKE 6
`define MPW_BIT_WAKE_EN 2
`define MPW_BIT_WAKE_SEEN 3
`define MPW_BIT_PULSE_MODE 7
`define MPW_BIT_PW_HI 9
`define MPW_BIT_PW_LO 8

`define MPW_RST_BASIC_CTRL 16'h0000
`define MPW_RST_INT_ENABLE 16'h0000
`define MPW_RST_WAKE_CTRL 16'h0000
`define MPW_RST_WAKE_OUT_CFG 16'h0000
`define MPW_RST_STATION 16'h0000

`define MPW_SYNC_BYTE 8'hFF
`define MPW_SYNC_LEN 3'h6
`define MPW_ADDR_COPIES 5'h10
`define MPW_ADDR_BYTES 3'h6

`define MPW_PW_CYC0 16'h0020
`define MPW_PW_CYC1 16'h0040
`define MPW_PW_CYC2 16'h0080
`define MPW_PW_CYC3 16'h0100

`endif

// ==== logic/mpw_pattern_match.v ====
// Byte scanner that finds a sync run followed by sixteen station address copies
`timescale 1ns/100ps
`include "mpw_defines.vh"

module mpw_pattern_match (
    input wire clk_sys,
    input wire arst_n,
    input wire enable,
    input wire frame_start,
    input wire byte_valid,
    input wire [7:0] byte_data,
    input wire [47:0] station_addr,
    output reg found
);

    reg [2:0] ff_run_r;
    reg [2:0] pos_r;
    reg [4:0] copy_r;
    reg in_addr_r;
    reg [7:0] exp_byte;

    // Address bytes go out word0 first, high byte of each word first
    always @* begin
        case (pos_r)
            3'h0: exp_byte = station_addr[47:40];
            3'h1: exp_byte = station_addr[39:32];
            3'h2: exp_byte = station_addr[31:24];
            3'h3: exp_byte = station_addr[23:16];
            3'h4: exp_byte = station_addr[15:8];
            3'h5: exp_byte = station_addr[7:0];
            default: exp_byte = 8'h00;
        endcase
    end

    wire sync_seen = (ff_run_r == `MPW_SYNC_LEN);
    wire first_hit = byte_data == station_addr[47:40];
    wire last_byte = (pos_r == `MPW_ADDR_BYTES - 3'h1) && (copy_r == `MPW_ADDR_COPIES - 5'h1);

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ff_run_r <= 3'h0;
            pos_r <= 3'h0;
            copy_r <= 5'h00;
            in_addr_r <= 1'b0;
            found <= 1'b0;
        end else if (!enable || frame_start) begin
            ff_run_r <= 3'h0;
            pos_r <= 3'h0;
            copy_r <= 5'h00;
            in_addr_r <= 1'b0;
            found <= 1'b0;
        end else if (byte_valid && !found) begin
            // Sync run counted on its own so it may start anywhere
            if (byte_data == `MPW_SYNC_BYTE) begin
                if (!sync_seen)
                    ff_run_r <= ff_run_r + 3'h1;
            end else begin
                ff_run_r <= 3'h0;
            end
            if (in_addr_r && byte_data == exp_byte) begin
                if (last_byte) begin
                    found <= 1'b1;
                    in_addr_r <= 1'b0;
                end else if (pos_r == `MPW_ADDR_BYTES - 3'h1) begin
                    pos_r <= 3'h0;
                    copy_r <= copy_r + 5'h01;
                end else begin
                    pos_r <= pos_r + 3'h1;
                end
            end else if (sync_seen && first_hit) begin
                // Mismatch restarts; a fresh sync run may reopen at once
                in_addr_r <= 1'b1;
                pos_r <= 3'h1;
                copy_r <= 5'h00;
            end else begin
                in_addr_r <= 1'b0;
                pos_r <= 3'h0;
                copy_r <= 5'h00;
            end
        end
    end

endmodule

// ==== verif/mpw_wake_detector_sva.sv ====
// Port assertions for the wake detector
`timescale 1ns/100ps
module mpw_wake_sva (
    input wire clk_sys,
    input wire arst_n,
    input wire [15:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_wdata,
    input wire [15:0] reg_rdata,
    input wire rx_frame_end,
    input wire rx_frame_good,
    input wire wake_strap_pad,
    input wire status_light_zero_o,
    input wire other_int_n,
    input wire general_interrupt_pin_oe,
    input wire mac_out_oe,
    input wire mac_tx_en_i,
    input wire core_tx_en
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    reg [15:0] cfg_r;
    reg [8:0] low_cnt_r;
    // Shadow of the output config so pulse width can be judged
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cfg_r <= 16'h0000;
            low_cnt_r <= 9'h000;
        end else begin
            if (reg_wr && reg_addr == 16'h4003) begin
                cfg_r <= reg_wdata;
            end
            low_cnt_r <= status_light_zero_o ? 9'h000 : low_cnt_r + 9'h001;
        end
    end
    a_wake_cause: assert property (
        wake_strap_pad && $fell(status_light_zero_o) |-> $past(rx_frame_end && rx_frame_good, 2))
        else $error("wake pin fell without good frame end");
    a_int_cause: assert property (
        $rose(general_interrupt_pin_oe) |-> $past(rx_frame_end, 2) || $past(reg_wr, 2) || !$past(other_int_n))
        else $error("interrupt raised without cause");
    a_pulse_width: assert property (
        wake_strap_pad && cfg_r[7] && $rose(status_light_zero_o) |-> low_cnt_r == (9'h020 << cfg_r[9:8]))
        else $error("wake pulse width wrong");
    a_level_hold: assert property (
        wake_strap_pad && !cfg_r[7] && !status_light_zero_o && !reg_wr && !$past(reg_wr)
        |=> !status_light_zero_o)
        else $error("level wake released early");
    a_isolate_oe: assert property (
        reg_wr && reg_addr == 16'h0000 && reg_wdata[10] |-> ##2 (!mac_out_oe && !core_tx_en))
        else $error("isolate did not float or block");
    a_tx_cause: assert property (
        core_tx_en |-> $past(mac_tx_en_i))
        else $error("transmit enable without mac request");
    a_unmapped_read: assert property (
        reg_rd && reg_addr > 16'h4006 |-> ##2 reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_int_clear: assert property (
        cfg_r[7] && reg_rd && reg_addr == 16'h0013 && !rx_frame_end && other_int_n
        ##1 !rx_frame_end && other_int_n |-> ##1 !general_interrupt_pin_oe)
        else $error("status read left interrupt set");
    c_wake: cover property ($fell(status_light_zero_o));
    c_pulse: cover property (cfg_r[7] && $rose(status_light_zero_o));
    c_iso: cover property (!mac_out_oe ##1 mac_out_oe);
endmodule

bind mpw_wake_detector mpw_wake_sva u_sva (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .rx_frame_end(rx_frame_end), .rx_frame_good(rx_frame_good), .wake_strap_pad(wake_strap_pad),
    .status_light_zero_o(status_light_zero_o), .other_int_n(other_int_n),
    .general_interrupt_pin_oe(general_interrupt_pin_oe), .mac_out_oe(mac_out_oe),
    .mac_tx_en_i(mac_tx_en_i), .core_tx_en(core_tx_en));

// ==== verif/mpw_mac_model.sv ====
// Far-side model: MAC transmit source and board pull-ups
`timescale 1ns/100ps
module mpw_mac_model (
    input wire clk_sys,
    input wire send,
    input wire status_light_zero_o,
    input wire status_light_zero_oe,
    input wire general_interrupt_pin_o,
    input wire general_interrupt_pin_oe,
    output logic wake_strap_pad,
    output logic [3:0] mac_txd_i,
    output logic mac_tx_en_i,
    output logic mac_tx_er_i,
    output logic [3:0] txd_prev,
    output wire wake_line_n,
    output wire int_line_n
);
    // Pull-ups hold both lines high when undriven
    assign wake_line_n = status_light_zero_oe ? status_light_zero_o : 1'b1;
    assign int_line_n = general_interrupt_pin_oe ? general_interrupt_pin_o : 1'b1;
    initial begin
        wake_strap_pad = 1'b1;
        mac_txd_i = 4'h0;
        mac_tx_en_i = 1'b0;
        mac_tx_er_i = 1'b0;
        txd_prev = 4'h0;
    end
    // Data keeps moving so a stuck copy is seen
    always @(negedge clk_sys) begin
        mac_txd_i <= mac_txd_i + 4'h3;
        mac_tx_en_i <= send;
    end
    always @(posedge clk_sys) begin
        txd_prev <= mac_txd_i;
    end
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for the wake detector
`timescale 1ns/100ps
module testbench;
    logic clk_sys, arst_n, reg_wr, reg_rd, rx_frame_start, rx_byte_valid, rx_frame_end, rx_frame_good;
    logic [15:0] reg_addr, reg_wdata, reg_rdata;
    logic [7:0] rx_byte;
    logic wake_strap_pad, led_activity, slz_o, slz_oe, other_int_n, gi_o, gi_oe, send;
    logic [3:0] core_rxd, mac_rxd_o, mac_txd_i, core_txd, txd_prev;
    logic core_rx_dv, core_rx_er, core_crs, core_col, mac_rx_dv_o, mac_rx_er_o, mac_crs_o, mac_col_o;
    logic mac_out_oe, mac_tx_en_i, mac_tx_er_i, core_tx_en, core_tx_er, wake_line_n, int_line_n;
    logic rd_d1 = 1'b0, rd_d2 = 1'b0;
    logic [7:0] crx_prev = 8'h00;
    logic [15:0] exq[$];
    logic [15:0] sa[3];
    int failures = 0, tests_run = 0, cyc = 0, n, seed;
    mpw_wake_detector u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rx_frame_start(rx_frame_start),
        .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_frame_end(rx_frame_end),
        .rx_frame_good(rx_frame_good), .wake_strap_pad(wake_strap_pad), .led_activity(led_activity),
        .status_light_zero_o(slz_o), .status_light_zero_oe(slz_oe), .other_int_n(other_int_n),
        .general_interrupt_pin_o(gi_o), .general_interrupt_pin_oe(gi_oe), .core_rxd(core_rxd),
        .core_rx_dv(core_rx_dv), .core_rx_er(core_rx_er), .core_crs(core_crs), .core_col(core_col),
        .mac_rxd_o(mac_rxd_o), .mac_rx_dv_o(mac_rx_dv_o), .mac_rx_er_o(mac_rx_er_o), .mac_crs_o(mac_crs_o),
        .mac_col_o(mac_col_o), .mac_out_oe(mac_out_oe), .mac_txd_i(mac_txd_i), .mac_tx_en_i(mac_tx_en_i),
        .mac_tx_er_i(mac_tx_er_i), .core_txd(core_txd), .core_tx_en(core_tx_en), .core_tx_er(core_tx_er));
    mpw_mac_model u_mac (.clk_sys(clk_sys), .send(send), .status_light_zero_o(slz_o),
        .status_light_zero_oe(slz_oe), .general_interrupt_pin_o(gi_o), .general_interrupt_pin_oe(gi_oe),
        .wake_strap_pad(wake_strap_pad), .mac_txd_i(mac_txd_i), .mac_tx_en_i(mac_tx_en_i),
        .mac_tx_er_i(mac_tx_er_i), .txd_prev(txd_prev), .wake_line_n(wake_line_n), .int_line_n(int_line_n));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk_sys);
        reg_wr = 1'b0;
        @(negedge clk_sys);
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        reg_addr = a;
        reg_rd = 1'b1;
        exq.push_back(e);
        @(negedge clk_sys);
        reg_rd = 1'b0;
        repeat (2) @(negedge clk_sys);
    endtask
    // Prefix, sync run, address copies, four tail bytes; one byte may be corrupted
    task automatic magic(input int pre, input int nff, input int ncp, input logic good, input int flip);
        logic [7:0] fq[$];
        logic [7:0] b;
        repeat (pre) fq.push_back(8'($urandom_range(0, 127)));
        repeat (nff) fq.push_back(8'hFF);
        for (int c = 0; c < ncp * 6; c++) begin
            b = 8'((c % 2) ? sa[(c % 6) / 2] : sa[(c % 6) / 2] >> 8);
            fq.push_back(c == flip ? ~b : b);
        end
        repeat (4) fq.push_back(8'h00);
        rx_frame_start = 1'b1;
        @(negedge clk_sys);
        rx_frame_start = 1'b0;
        foreach (fq[i]) begin
            rx_byte = fq[i];
            rx_byte_valid = 1'b1;
            @(negedge clk_sys);
        end
        rx_byte_valid = 1'b0;
        rx_byte = ~rx_byte;
        rx_frame_end = 1'b1;
        rx_frame_good = good;
        @(negedge clk_sys);
        rx_frame_end = 1'b0;
        @(negedge clk_sys);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        rd_d1 <= reg_rd;
        rd_d2 <= rd_d1;
        cyc++;
        if (cyc == 20000) begin
            failures++;
            results();
        end
    end
    always @(negedge clk_sys) begin
        // Receive side copies must trail the core inputs by one edge
        if (arst_n && cyc > 4) check({mac_rxd_o, mac_rx_dv_o, mac_rx_er_o, mac_crs_o, mac_col_o}, crx_prev);
        crx_prev = 8'($urandom);
        {core_rxd, core_rx_dv, core_rx_er, core_crs, core_col} = crx_prev;
        if (rd_d2 && exq.size() > 0) check(reg_rdata, exq.pop_front());
    end

    initial begin
        {arst_n, reg_wr, reg_rd, rx_frame_start, rx_byte_valid, rx_frame_end, rx_frame_good, send} = 8'h00;
        {reg_addr, reg_wdata, rx_byte} = 40'h00_0000_0000;
        {led_activity, other_int_n} = 2'b11;
        seed = $urandom(32'h0327_7372);
        repeat (2) @(negedge clk_sys);
        arst_n = 1'b1;
        @(negedge clk_sys);
        foreach (sa[i]) rd(16'h4004 + 16'(i), 16'h0000);
        rd(16'h4000, 16'h0000);
        wr(16'h0013, 16'hFFFF);
        rd(16'h0013, 16'h0000);
        rd(16'h4010, 16'h0000);
        foreach (sa[i]) begin
            sa[i] = 16'($urandom) & 16'h7F7F;
            wr(16'h4004 + 16'(i), sa[i]);
            rd(16'h4004 + 16'(i), sa[i]);
        end
        wr(16'h0012, 16'h0040);
        magic(3, 6, 16, 1'b1, -1);
        check(wake_line_n, 1'b1);
        wr(16'h4000, 16'h0004);
        magic(4, 6, 16, 1'b0, -1);
        check(wake_line_n, 1'b1);
        magic(2, 5, 16, 1'b1, -1);
        check(wake_line_n, 1'b1);
        magic(0, 6, 16, 1'b1, 95);
        check(wake_line_n, 1'b1);
        magic($urandom_range(0, 20), 6, 16, 1'b1, -1);
        check({wake_line_n, int_line_n}, 2'b00);
        rd(16'h4000, 16'h000C);
        rd(16'h0013, 16'h0040);
        check(int_line_n, 1'b0);
        wr(16'h4000, 16'h0000);
        check(wake_line_n, 1'b1);
        wr(16'h4000, 16'h0004);
        for (int w = 0; w < 4; w++) begin
            wr(16'h4003, 16'h0080 | (16'(w) << 8));
            magic(1, 7, 16, 1'b1, -1);
            n = 0;
            while (!wake_line_n && n < 300) begin
                @(negedge clk_sys);
                n++;
            end
            check(16'(n), 16'h0020 << w);
            check(int_line_n, 1'b0);
            rd(16'h0013, 16'h0040);
            check(int_line_n, 1'b1);
            wr(16'h4000, 16'h000C);
            rd(16'h4000, 16'h0004);
        end
        send = 1'b1;
        repeat (3) @(negedge clk_sys);
        check({mac_out_oe, core_tx_en, core_txd}, {2'b11, txd_prev});
        wr(16'h0000, 16'h0400);
        check({mac_out_oe, core_tx_en, core_txd}, 6'h00);
        wr(16'h0000, 16'h0000);
        check({mac_out_oe, core_tx_en, core_txd}, {2'b11, txd_prev});
        send = 1'b0;
        results();
    end
endmodule
